// ### design/ssx_defs.svh
`ifndef SSX_DEFS_SVH
`define SSX_DEFS_SVH

// software register map (word index on the register port)
`define SSX_REG_ACC 3'h0
`define SSX_REG_STATUS 3'h1
`define SSX_REG_DIR_A 3'h2
`define SSX_REG_DIR_B 3'h3
`define SSX_REG_DIR_C 3'h4
`define SSX_REG_RESULT 3'h5

// status field positions
`define SSX_BIT_CARRY 0
`define SSX_BIT_NIBBLE 1
`define SSX_BIT_ZERO 2

// reset values
`define SSX_RST_ACC 8'h00
`define SSX_RST_FLAGS 1'b0
`define SSX_RST_DIR 8'hFF

// operand values of the load-direction operation
`define SSX_DIR_SEL_A 7'h05
`define SSX_DIR_SEL_B 7'h06
`define SSX_DIR_SEL_C 7'h07

// destination bit values
`define SSX_DEST_ACC 1'b0
`define SSX_DEST_FILE 1'b1

`endif

// ### design/ssx_exec.sv
// What this block does
// - literal minus accumulator goes to accumulator; carry clear only when accumulator exceeds literal
// - literal form: nibble carry clear when accumulator low nibble exceeds literal low nibble
// - file value minus accumulator; carry clear only when accumulator exceeds file value
// - file form: nibble carry clear when accumulator low nibble exceeds file low nibble
// - destination bit 0 writes accumulator, 1 writes back the addressed file register
// - borrow form subtracts accumulator and inverted carry; routed by destination; updates three flags
// - nibble exchange swaps file halves into destination; no flag changes
// - load direction copies accumulator to port A, B or C direction for 5, 6, 7
// - xor with literal lands in accumulator; only zero flag changes
// - xor with file register routed by destination; only zero flag changes
`timescale 1ns/1ns
`include "ssx_defs.svh"
module ssx_exec (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic op_valid,
  input wire ssx_pkg::ssx_op_t op_code,
  input wire logic op_dest,
  input wire logic [6:0] op_file_addr,
  input wire logic [7:0] op_literal,
  input wire logic [7:0] file_rdata,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic file_wr_en,
  output logic [6:0] file_waddr,
  output logic [7:0] file_wdata,
  output logic [7:0] acc_out,
  output logic carry_flag,
  output logic nibble_carry_flag,
  output logic zero_flag,
  output logic [7:0] port_a_direction,
  output logic [7:0] port_b_direction,
  output logic [7:0] port_c_direction
);
  logic [7:0] acc_reg, acc_next;
  logic carry_reg, carry_next;
  logic nibble_carry_reg, nibble_carry_next;
  logic zero_reg, zero_next;
  logic [7:0] port_a_direction_reg, port_a_direction_next;
  logic [7:0] port_b_direction_reg, port_b_direction_next;
  logic [7:0] port_c_direction_reg, port_c_direction_next;
  logic [7:0] result_reg, result_next;
  logic file_wr_en_reg, file_wr_en_next;
  logic [6:0] file_waddr_reg, file_waddr_next;
  logic [7:0] file_wdata_reg, file_wdata_next;
  logic [7:0] rdata_reg, rdata_next;

  logic [7:0] sub_minuend;
  logic sub_cin;
  logic [7:0] sub_diff;
  logic sub_cout;
  logic sub_nibble;
  logic [7:0] op_result;
  logic writes_result;
  logic is_file_op;

  // one subtractor serves all three subtract forms through the operand mux
  always_comb begin
    sub_minuend = file_rdata;
    sub_cin = 1'b1;
    if (op_code == ssx_pkg::sub_acc_from_literal_op) begin
      sub_minuend = op_literal;
    end
    if (op_code == ssx_pkg::sub_with_borrow_op) begin
      sub_cin = carry_reg;
    end
  end

  ssx_sub8 #(
    .W(8)
  ) u_sub (
    .minuend(sub_minuend),
    .subtrahend(acc_reg),
    .no_borrow_in(sub_cin),
    .diff(sub_diff),
    .no_borrow_out(sub_cout),
    .nibble_no_borrow(sub_nibble)
  );

  always_comb begin
    op_result = 8'h00;
    writes_result = 1'b0;
    is_file_op = 1'b0;
    unique case (op_code)
      ssx_pkg::ssx_no_op: begin
        op_result = 8'h00;
      end
      ssx_pkg::sub_acc_from_literal_op: begin
        op_result = sub_diff;
        writes_result = 1'b1;
      end
      ssx_pkg::sub_acc_from_file_op: begin
        op_result = sub_diff;
        writes_result = 1'b1;
        is_file_op = 1'b1;
      end
      ssx_pkg::sub_with_borrow_op: begin
        op_result = sub_diff;
        writes_result = 1'b1;
        is_file_op = 1'b1;
      end
      ssx_pkg::nibble_exchange_op: begin
        op_result = {file_rdata[3:0], file_rdata[7:4]};
        writes_result = 1'b1;
        is_file_op = 1'b1;
      end
      ssx_pkg::load_direction_op: begin
        op_result = acc_reg;
      end
      ssx_pkg::xor_literal_op: begin
        op_result = acc_reg ^ op_literal;
        writes_result = 1'b1;
      end
      ssx_pkg::xor_file_op: begin
        op_result = acc_reg ^ file_rdata;
        writes_result = 1'b1;
        is_file_op = 1'b1;
      end
    endcase
  end

  // an operation in the same cycle as a software write takes precedence:
  // the core must never lose an instruction result
  always_comb begin
    acc_next = acc_reg;
    carry_next = carry_reg;
    nibble_carry_next = nibble_carry_reg;
    zero_next = zero_reg;
    port_a_direction_next = port_a_direction_reg;
    port_b_direction_next = port_b_direction_reg;
    port_c_direction_next = port_c_direction_reg;
    result_next = result_reg;
    file_wr_en_next = 1'b0;
    file_waddr_next = file_waddr_reg;
    file_wdata_next = file_wdata_reg;
    if (op_valid) begin
      if (writes_result) begin
        result_next = op_result;
        if (is_file_op && op_dest == `SSX_DEST_FILE) begin
          file_wr_en_next = 1'b1;
          file_waddr_next = op_file_addr;
          file_wdata_next = op_result;
        end else begin
          acc_next = op_result;
        end
      end
      unique case (op_code)
        ssx_pkg::sub_acc_from_literal_op,
        ssx_pkg::sub_acc_from_file_op,
        ssx_pkg::sub_with_borrow_op: begin
          carry_next = sub_cout;
          nibble_carry_next = sub_nibble;
          zero_next = (op_result == 8'h00);
        end
        ssx_pkg::xor_literal_op,
        ssx_pkg::xor_file_op: begin
          zero_next = (op_result == 8'h00);
        end
        ssx_pkg::load_direction_op: begin
          if (op_file_addr == `SSX_DIR_SEL_A) begin
            port_a_direction_next = acc_reg;
          end
          if (op_file_addr == `SSX_DIR_SEL_B) begin
            port_b_direction_next = acc_reg;
          end
          if (op_file_addr == `SSX_DIR_SEL_C) begin
            port_c_direction_next = acc_reg;
          end
        end
        ssx_pkg::ssx_no_op,
        ssx_pkg::nibble_exchange_op: begin
          zero_next = zero_reg;
        end
      endcase
    end else if (reg_wr) begin
      unique case (reg_addr)
        `SSX_REG_ACC: begin
          acc_next = reg_wdata;
        end
        `SSX_REG_STATUS: begin
          carry_next = reg_wdata[`SSX_BIT_CARRY];
          nibble_carry_next = reg_wdata[`SSX_BIT_NIBBLE];
          zero_next = reg_wdata[`SSX_BIT_ZERO];
        end
        `SSX_REG_DIR_A: begin
          port_a_direction_next = reg_wdata;
        end
        `SSX_REG_DIR_B: begin
          port_b_direction_next = reg_wdata;
        end
        `SSX_REG_DIR_C: begin
          port_c_direction_next = reg_wdata;
        end
        default: begin
          result_next = result_reg;
        end
      endcase
    end
  end

  // read data stands only in the cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `SSX_REG_ACC: rdata_next = acc_reg;
        `SSX_REG_STATUS: begin
          rdata_next[`SSX_BIT_CARRY] = carry_reg;
          rdata_next[`SSX_BIT_NIBBLE] = nibble_carry_reg;
          rdata_next[`SSX_BIT_ZERO] = zero_reg;
        end
        `SSX_REG_DIR_A: rdata_next = port_a_direction_reg;
        `SSX_REG_DIR_B: rdata_next = port_b_direction_reg;
        `SSX_REG_DIR_C: rdata_next = port_c_direction_reg;
        `SSX_REG_RESULT: rdata_next = result_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_reg <= `SSX_RST_ACC;
      carry_reg <= `SSX_RST_FLAGS;
      nibble_carry_reg <= `SSX_RST_FLAGS;
      zero_reg <= `SSX_RST_FLAGS;
      port_a_direction_reg <= `SSX_RST_DIR;
      port_b_direction_reg <= `SSX_RST_DIR;
      port_c_direction_reg <= `SSX_RST_DIR;
      result_reg <= 8'h00;
      file_wr_en_reg <= 1'b0;
      file_waddr_reg <= 7'h00;
      file_wdata_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end else begin
      acc_reg <= acc_next;
      carry_reg <= carry_next;
      nibble_carry_reg <= nibble_carry_next;
      zero_reg <= zero_next;
      port_a_direction_reg <= port_a_direction_next;
      port_b_direction_reg <= port_b_direction_next;
      port_c_direction_reg <= port_c_direction_next;
      result_reg <= result_next;
      file_wr_en_reg <= file_wr_en_next;
      file_waddr_reg <= file_waddr_next;
      file_wdata_reg <= file_wdata_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign file_wr_en = file_wr_en_reg;
  assign file_waddr = file_waddr_reg;
  assign file_wdata = file_wdata_reg;
  assign acc_out = acc_reg;
  assign carry_flag = carry_reg;
  assign nibble_carry_flag = nibble_carry_reg;
  assign zero_flag = zero_reg;
  assign port_a_direction = port_a_direction_reg;
  assign port_b_direction = port_b_direction_reg;
  assign port_c_direction = port_c_direction_reg;

  // reference values that only the checks below read
  logic [7:0] chk_lit_diff;
  logic [7:0] chk_file_diff;
  logic [7:0] chk_borrow_diff;
  logic chk_lit_ge;
  logic chk_lit_nib_ge;
  logic chk_file_ge;
  logic chk_file_nib_ge;
  logic chk_is_op;
  assign chk_lit_diff = op_literal - acc_reg;
  assign chk_file_diff = file_rdata - acc_reg;
  assign chk_borrow_diff = file_rdata - acc_reg - {7'h00, ~carry_reg};
  assign chk_lit_ge = acc_reg <= op_literal;
  assign chk_lit_nib_ge = acc_reg[3:0] <= op_literal[3:0];
  assign chk_file_ge = acc_reg <= file_rdata;
  assign chk_file_nib_ge = acc_reg[3:0] <= file_rdata[3:0];
  assign chk_is_op = op_valid;
  // borrow form compares in nine and five bits so the inverted carry cannot wrap
  logic chk_borrow_ge;
  logic chk_borrow_nib_ge;
  logic [7:0] chk_xor_val;
  assign chk_borrow_ge = {1'b0, acc_reg} + {8'h00, ~carry_reg} <= {1'b0, file_rdata};
  assign chk_borrow_nib_ge = {1'b0, acc_reg[3:0]} + {4'h0, ~carry_reg} <= {1'b0, file_rdata[3:0]};
  assign chk_xor_val = acc_reg ^ ((op_code == ssx_pkg::xor_literal_op) ? op_literal : file_rdata);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sub_acc_from_literal_op_flags_a: assert property (
    chk_is_op && op_code == ssx_pkg::sub_acc_from_literal_op |=>
      acc_reg == $past(chk_lit_diff) && carry_reg == $past(chk_lit_ge)
      && nibble_carry_reg == $past(chk_lit_nib_ge)
      && zero_reg == ($past(chk_lit_diff) == 8'h00))
    else $error("literal subtract result or flags wrong");

  sub_acc_from_file_op_flags_a: assert property (
    chk_is_op && op_code == ssx_pkg::sub_acc_from_file_op |=>
      result_reg == $past(chk_file_diff) && carry_reg == $past(chk_file_ge)
      && nibble_carry_reg == $past(chk_file_nib_ge))
    else $error("file subtract result or flags wrong");

  dest_file_a: assert property (
    chk_is_op && is_file_op && op_dest |=>
      file_wr_en && file_waddr == $past(op_file_addr) && acc_reg == $past(acc_reg) ##1 !file_wr_en || $past(op_valid))
    else $error("file destination write wrong");

  dest_acc_a: assert property (
    chk_is_op && writes_result && !(is_file_op && op_dest) |=> !file_wr_en && acc_reg == result_reg)
    else $error("accumulator destination wrong");

  borrow_sub_a: assert property (
    chk_is_op && op_code == ssx_pkg::sub_with_borrow_op |=> result_reg == $past(chk_borrow_diff))
    else $error("borrow subtract wrong");

  swap_flags_a: assert property (
    chk_is_op && op_code == ssx_pkg::nibble_exchange_op |=>
      $stable(carry_reg) && $stable(nibble_carry_reg) && $stable(zero_reg)
      && result_reg == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
    else $error("nibble exchange wrong");

  dir_load_a: assert property (
    chk_is_op && op_code == ssx_pkg::load_direction_op && op_file_addr == `SSX_DIR_SEL_B |=>
      port_b_direction_reg == $past(acc_reg) && $stable(port_a_direction_reg) && $stable(carry_reg))
    else $error("direction load wrong");

  xor_zero_a: assert property (
    chk_is_op && (op_code == ssx_pkg::xor_literal_op || op_code == ssx_pkg::xor_file_op) |=>
      zero_reg == (result_reg == 8'h00) && $stable(carry_reg) && $stable(nibble_carry_reg))
    else $error("xor flag update wrong");

  borrow_flags_a: assert property (
    chk_is_op && op_code == ssx_pkg::sub_with_borrow_op |=>
      carry_reg == $past(chk_borrow_ge) && nibble_carry_reg == $past(chk_borrow_nib_ge)
      && zero_reg == ($past(chk_borrow_diff) == 8'h00))
    else $error("borrow subtract flags wrong");

  xor_result_a: assert property (
    chk_is_op && (op_code == ssx_pkg::xor_literal_op || op_code == ssx_pkg::xor_file_op) |=>
      result_reg == $past(chk_xor_val) && zero_reg == ($past(chk_xor_val) == 8'h00))
    else $error("xor result wrong");
endmodule

// ### design/ssx_pkg.sv
package ssx_pkg;

  typedef enum logic [2:0] {
    ssx_no_op = 3'h0,
    sub_acc_from_literal_op = 3'h1,
    sub_acc_from_file_op = 3'h2,
    sub_with_borrow_op = 3'h3,
    nibble_exchange_op = 3'h4,
    load_direction_op = 3'h5,
    xor_literal_op = 3'h6,
    xor_file_op = 3'h7
  } ssx_op_t;

endpackage

// ### design/ssx_sub8.sv
`timescale 1ns/1ns
// two's complement subtract as minuend + ~subtrahend + carry-in;
// carry out high means no borrow was needed
module ssx_sub8 #(
  parameter int W = 8
) (
  input wire logic [W-1:0] minuend,
  input wire logic [W-1:0] subtrahend,
  input wire logic no_borrow_in,
  output logic [W-1:0] diff,
  output logic no_borrow_out,
  output logic nibble_no_borrow
);
  logic [W:0] sum;
  logic [4:0] low;

  assign sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {{W{1'b0}}, no_borrow_in};
  assign low = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, no_borrow_in};
  assign diff = sum[W-1:0];
  assign no_borrow_out = sum[W];
  assign nibble_no_borrow = low[4];
endmodule

// ### tb/ssx_exec_tb.sv
`timescale 1ns/1ns
`include "ssx_defs.svh"
module ssx_exec_tb;
  localparam ssx_pkg::ssx_op_t op_sl = ssx_pkg::sub_acc_from_literal_op;
  localparam ssx_pkg::ssx_op_t op_sf = ssx_pkg::sub_acc_from_file_op;
  localparam ssx_pkg::ssx_op_t op_sb = ssx_pkg::sub_with_borrow_op;
  localparam ssx_pkg::ssx_op_t op_sw = ssx_pkg::nibble_exchange_op;
  localparam ssx_pkg::ssx_op_t op_ld = ssx_pkg::load_direction_op;
  localparam ssx_pkg::ssx_op_t op_xl = ssx_pkg::xor_literal_op;
  localparam ssx_pkg::ssx_op_t op_xf = ssx_pkg::xor_file_op;
  localparam logic [7:0] sl_acc [4] = '{8'h05, 8'h06, 8'h1F, 8'h20};
  localparam logic [7:0] sl_lit [4] = '{8'h05, 8'h05, 8'h20, 8'h1F};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic op_valid = 1'b0;
  ssx_pkg::ssx_op_t op_code = ssx_pkg::ssx_no_op;
  logic op_dest = 1'b0;
  logic [6:0] op_file_addr = 7'h00;
  logic [7:0] op_literal = 8'h00;
  logic [7:0] file_rdata = 8'h00;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, file_wdata, acc_out, port_a_direction, port_b_direction, port_c_direction;
  logic [6:0] file_waddr;
  logic file_wr_en, carry_flag, nibble_carry_flag, zero_flag;
  int n_fail = 0;
  int num_checks = 0;
  // reference model of the architectural state
  logic [7:0] e_acc = 8'h00;
  logic e_c = 1'b0;
  logic e_nc = 1'b0;
  logic e_z = 1'b0;
  logic e_we = 1'b0;
  logic [6:0] e_wa = 7'h00;
  logic [7:0] e_wd = 8'h00;
  logic [7:0] e_dir [3] = '{8'hFF, 8'hFF, 8'hFF};

  always #50 clk = ~clk;

  ssx_exec u_dut (
    .clk(clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_code(op_code), .op_dest(op_dest),
    .op_file_addr(op_file_addr), .op_literal(op_literal), .file_rdata(file_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .file_wr_en(file_wr_en), .file_waddr(file_waddr), .file_wdata(file_wdata),
    .acc_out(acc_out), .carry_flag(carry_flag), .nibble_carry_flag(nibble_carry_flag),
    .zero_flag(zero_flag), .port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
    .port_c_direction(port_c_direction)
  );

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_state();
    chk("acc", e_acc, acc_out);
    chk("carry", {7'h00, e_c}, {7'h00, carry_flag});
    chk("nibble_carry", {7'h00, e_nc}, {7'h00, nibble_carry_flag});
    chk("zero", {7'h00, e_z}, {7'h00, zero_flag});
    chk("dir_a", e_dir[0], port_a_direction);
    chk("dir_b", e_dir[1], port_b_direction);
    chk("dir_c", e_dir[2], port_c_direction);
    chk("file_wr_en", {7'h00, e_we}, {7'h00, file_wr_en});
    if (e_we) begin
      chk("file_waddr", {1'b0, e_wa}, {1'b0, file_waddr});
      chk("file_wdata", e_wd, file_wdata);
    end
  endtask

  // hold keeps op_valid up so the next call issues at the very next edge
  task automatic run_op(input ssx_pkg::ssx_op_t code, input logic dest, input logic [6:0] adr,
      input logic [7:0] lit, input logic [7:0] frd, input logic hold);
    logic [7:0] m;
    logic [7:0] r;
    logic cin;
    logic [8:0] t;
    logic [4:0] n;
    m = (code == op_sl || code == op_xl) ? lit : frd;
    cin = (code == op_sb) ? e_c : 1'b1;
    t = {1'b0, m} + {1'b0, ~e_acc} + {8'h00, cin};
    n = {1'b0, m[3:0]} + {1'b0, ~e_acc[3:0]} + {4'h0, cin};
    r = (code == op_sw) ? {m[3:0], m[7:4]} : (code == op_xl || code == op_xf) ? (e_acc ^ m) : t[7:0];
    if (code inside {op_sl, op_sf, op_sb}) begin
      e_c = t[8];
      e_nc = n[4];
    end
    if (code inside {op_sl, op_sf, op_sb, op_xl, op_xf})
      e_z = (r == 8'h00);
    e_we = dest && (code inside {op_sf, op_sb, op_sw, op_xf});
    if (e_we) begin
      e_wa = adr;
      e_wd = r;
    end else if (code == op_ld) begin
      if (adr inside {`SSX_DIR_SEL_A, `SSX_DIR_SEL_B, `SSX_DIR_SEL_C})
        e_dir[adr - `SSX_DIR_SEL_A] = e_acc;
    end else if (code != ssx_pkg::ssx_no_op) begin
      e_acc = r;
    end
    op_valid <= 1'b1;
    op_code <= code;
    op_dest <= dest;
    op_file_addr <= adr;
    op_literal <= lit;
    file_rdata <= frd;
    @(posedge clk);
    if (!hold) begin
      op_valid <= 1'b0;
      @(negedge clk);
      chk_state();
      @(posedge clk);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
    if (a == `SSX_REG_ACC)
      e_acc = d;
    if (a == `SSX_REG_STATUS) begin
      e_c = d[`SSX_BIT_CARRY];
      e_nc = d[`SSX_BIT_NIBBLE];
      e_z = d[`SSX_BIT_ZERO];
    end
  endtask

  task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("reg_rdata", exp, reg_rdata);
    @(negedge clk);
    chk("reg_rdata_idle", 8'h00, reg_rdata);
    @(posedge clk);
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk_state();
    @(posedge clk);
    rd_reg(`SSX_REG_STATUS, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr_reg(`SSX_REG_ACC, sl_acc[i]);
      run_op(op_sl, 1'b1, 7'h00, sl_lit[i], 8'h00, 1'b0);
    end
    rd_reg(`SSX_REG_STATUS, {5'h00, e_z, e_nc, e_c});
    wr_reg(`SSX_REG_ACC, 8'h05);
    run_op(op_sf, 1'b1, 7'h0A, 8'h00, 8'h20, 1'b0);
    run_op(op_sf, 1'b0, 7'h7F, 8'h00, 8'h03, 1'b0);
    wr_reg(`SSX_REG_STATUS, 8'h00);
    wr_reg(`SSX_REG_ACC, 8'h05);
    run_op(op_sb, 1'b0, 7'h01, 8'h00, 8'h10, 1'b0);
    run_op(op_sb, 1'b1, 7'h02, 8'h00, 8'h0B, 1'b0);
    run_op(op_sb, 1'b1, 7'h03, 8'h00, 8'h0A, 1'b0);
    wr_reg(`SSX_REG_STATUS, 8'h07);
    run_op(op_sw, 1'b0, 7'h04, 8'h00, 8'h3C, 1'b0);
    run_op(op_sw, 1'b1, 7'h7F, 8'h00, 8'hA5, 1'b0);
    for (int s = 4; s < 8; s++) begin
      wr_reg(`SSX_REG_ACC, 8'(8'h40 + s));
      run_op(op_ld, 1'b0, 7'(s), 8'h00, 8'h00, 1'b0);
    end
    run_op(ssx_pkg::ssx_no_op, 1'b1, 7'h05, 8'h55, 8'h55, 1'b0);
    wr_reg(`SSX_REG_STATUS, 8'h03);
    wr_reg(`SSX_REG_ACC, 8'hA5);
    run_op(op_xl, 1'b1, 7'h00, 8'hA5, 8'h00, 1'b0);
    run_op(op_xf, 1'b1, 7'h33, 8'h00, 8'h0F, 1'b0);
    run_op(op_xf, 1'b0, 7'h34, 8'h00, 8'hF0, 1'b0);
    // back to back: each op must see the state left by the one before
    run_op(op_sl, 1'b0, 7'h00, 8'h00, 8'h00, 1'b1);
    run_op(op_xf, 1'b0, 7'h11, 8'h00, 8'h10, 1'b1);
    run_op(op_sb, 1'b1, 7'h12, 8'h00, 8'h05, 1'b0);
    rd_reg(`SSX_REG_ACC, e_acc);
    rd_reg(`SSX_REG_STATUS, {5'h00, e_z, e_nc, e_c});
    rd_reg(`SSX_REG_DIR_B, e_dir[1]);
    rd_reg(3'h7, 8'h00);
    // result register is read-only: a software write must leave the last result
    wr_reg(`SSX_REG_RESULT, 8'hEE);
    rd_reg(`SSX_REG_RESULT, e_wd);
    // reset in mid-run must bring back every architectural reset value
    sys_rst <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    sys_rst <= 1'b0;
    e_acc = `SSX_RST_ACC;
    e_c = `SSX_RST_FLAGS;
    e_nc = `SSX_RST_FLAGS;
    e_z = `SSX_RST_FLAGS;
    e_we = 1'b0;
    e_dir = '{`SSX_RST_DIR, `SSX_RST_DIR, `SSX_RST_DIR};
    @(negedge clk);
    chk_state();
    @(posedge clk);
    run_op(op_sl, 1'b0, 7'h00, 8'h01, 8'h00, 1'b0);
    stop_test();
  end
endmodule
